// [rtl/ptd_panel_trap.sv]
module ptd_panel_trap (
   // clocking
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   // processor cycle timing
   input  wire logic        cycle_start,
   input  wire logic        timing_state_two,
   input  wire logic        last_execute,
   input  wire logic        operate_group2_cycle,
   // instruction fetch and decode
   input  wire logic        fetch_strobe,
   input  wire logic [11:0] instr_word,
   input  wire logic [11:0] pc_value,
   input  wire logic        interrupts_on_op,
   input  wire logic        interrupts_off_op,
   input  wire logic        restore_flags_op,
   // memory reference classification
   input  wire logic        ref_valid,
   input  wire logic [1:0]  ref_kind,
   // board control from firmware
   input  wire logic        single_step_mode,
   input  wire logic        main_data_select,
   input  wire logic        request_clear,
   // serial ports
   input  wire logic        frame_err_primary,
   input  wire logic        frame_err_secondary,
   input  wire logic        term_ready_in,
   // bus pins
   input  wire logic        dma_request_n,
   input  wire logic        dev_int_request_n,
   input  wire logic        power_request_n,
   // panel status
   output logic             panel_mode_flag,
   output logic             panel_request,
   output logic             trap_flag,
   output logic             run,
   output logic             interrupt_enable_flag,
   output logic             int_grant,
   output logic             term_flag,
   // memory steering and entry transfers
   output logic             mem_panel_sel,
   output logic             mem_write,
   output logic [11:0]      mem_addr,
   output logic [11:0]      mem_data,
   output logic             pc_load,
   output logic [11:0]      pc_load_value,
   // DMA and bus release
   output logic             dma_grant,
   output logic             bus_oe_n
);
   ptd_pkg::ptd_state_t state_reg;
   logic [2:0]          sync1_reg;
   logic [2:0]          sync2_reg;
   logic [11:0]         instr_reg;
   logic                instr_main_reg;
   logic                halt_flag_reg;
   logic                reset_entry_reg;
   logic                ion_exit_reg;
   logic                exit_armed_reg;
   logic                ion_pend_reg;
   logic                sample;
   logic                grant_panel;
   logic                grant_dma;
   logic                grant_int;
   logic                dma_n_s;
   logic                int_n_s;
   logic                pwr_n_s;
   logic                request_next;

   function automatic logic is_opr2(input logic [11:0] w);
      is_opr2 = (w[ptd_pkg::OPR2_HI:ptd_pkg::OPR2_LO]
                 == ptd_pkg::OPR2_PREFIX)
                && !w[ptd_pkg::OPR2_CLASS_BIT];
   endfunction

   function automatic logic is_trapped(input logic [11:0] w);
      is_trapped = (w >= ptd_pkg::IOT_TRAP_LO
                    && w <= ptd_pkg::IOT_TRAP_HI)
                   || (is_opr2(w) && w[ptd_pkg::OSR_BIT]);
   endfunction

   function automatic logic is_halt(input logic [11:0] w);
      is_halt = is_opr2(w) && w[ptd_pkg::HLT_BIT];
   endfunction

   // two-stage synchronisers for the bus pins
   genvar gi;
   generate
      for (gi = 0; gi < ptd_pkg::SYNC_W; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            if (rst) begin
               sync1_reg[gi] <= 1'b1;
               sync2_reg[gi] <= 1'b1;
            end else if (ce) begin
               sync2_reg[gi] <= sync1_reg[gi];
               case (gi)
                  ptd_pkg::SYNC_DMA: sync1_reg[gi] <= dma_request_n;
                  ptd_pkg::SYNC_INT: sync1_reg[gi] <= dev_int_request_n;
                  default:           sync1_reg[gi] <= power_request_n;
               endcase
            end
         end
      end
   endgenerate

   assign dma_n_s = sync2_reg[ptd_pkg::SYNC_DMA];
   assign int_n_s = sync2_reg[ptd_pkg::SYNC_INT];
   assign pwr_n_s = sync2_reg[ptd_pkg::SYNC_PWR];

   // request sampling and fixed priority
   assign sample = timing_state_two && last_execute
                   && state_reg == ptd_pkg::ST_RUN; // RULE_04
   assign grant_panel = sample && panel_request
                        && !panel_mode_flag; // RULE_01 RULE_05 RULE_23
   assign grant_dma = sample && !panel_request && !panel_mode_flag
                      && !dma_n_s; // RULE_19 RULE_23
   assign grant_int = sample && !panel_request && !panel_mode_flag
                      && dma_n_s && !int_n_s
                      && interrupt_enable_flag; // RULE_23

   // every source is on-board except the synchronised bus power request pin
   assign request_next = trap_flag || halt_flag_reg // RULE_03
                         || reset_entry_reg
                         || frame_err_primary
                         || frame_err_secondary // RULE_12
                         || !pwr_n_s; // RULE_18

   always_ff @(posedge clock) begin
      if (rst) begin
         panel_request <= 1'b0;
      end else if (ce) begin
         panel_request <= request_next;
      end
   end

   // instruction capture for later decode
   always_ff @(posedge clock) begin
      if (rst) begin
         instr_reg      <= 12'h000;
         instr_main_reg <= 1'b0;
      end else if (ce && fetch_strobe) begin
         instr_reg      <= instr_word;
         instr_main_reg <= !panel_mode_flag;
      end
   end

   // trap flag: a new trap wins over the firmware clear
   always_ff @(posedge clock) begin
      if (rst) begin
         trap_flag <= 1'b0; // RULE_25
      end else if (ce) begin
         if (fetch_strobe && !panel_mode_flag
             && (single_step_mode // RULE_15
                 || is_trapped(instr_word))) begin // RULE_14
            trap_flag <= 1'b1;
         end else if (request_clear) begin
            trap_flag <= 1'b0;
         end
      end
   end

   // halt in main memory, caught at the group two cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         halt_flag_reg <= 1'b0;
      end else if (ce) begin
         if (operate_group2_cycle && instr_main_reg
             && is_halt(instr_reg)) begin
            halt_flag_reg <= 1'b1; // RULE_16
         end else if (request_clear) begin
            halt_flag_reg <= 1'b0;
         end
      end
   end

   // run held low in reset, panel entry pending on release
   always_ff @(posedge clock) begin
      if (rst) begin
         run             <= 1'b0; // RULE_17
         reset_entry_reg <= 1'b1;
      end else if (ce) begin
         run <= 1'b1;
         if (request_clear) begin
            reset_entry_reg <= 1'b0;
         end
      end
   end

   // panel mode flag and its exits
   always_ff @(posedge clock) begin
      if (rst) begin
         panel_mode_flag <= 1'b0; // RULE_11 RULE_25
      end else if (ce) begin
         if (grant_panel) begin
            panel_mode_flag <= 1'b1; // RULE_04
         end else if (restore_flags_op) begin
            panel_mode_flag <= 1'b0; // RULE_10
         end else if (exit_armed_reg && timing_state_two) begin
            panel_mode_flag <= 1'b0; // RULE_09
         end
      end
   end

   // interrupts on in panel mode arms an exit in the next instruction
   always_ff @(posedge clock) begin
      if (rst) begin
         ion_exit_reg   <= 1'b0;
         exit_armed_reg <= 1'b0;
      end else if (ce) begin
         if (interrupts_on_op && panel_mode_flag) begin
            ion_exit_reg <= 1'b1; // RULE_09
         end else if (fetch_strobe) begin
            ion_exit_reg <= 1'b0;
         end
         if (fetch_strobe && ion_exit_reg) begin
            exit_armed_reg <= 1'b1;
         end else if (timing_state_two) begin
            exit_armed_reg <= 1'b0;
         end
      end
   end

   // device interrupt enable; set one fetch after interrupts on
   always_ff @(posedge clock) begin
      if (rst) begin
         interrupt_enable_flag <= 1'b0;
         ion_pend_reg          <= 1'b0;
      end else if (ce) begin
         if (interrupts_on_op && !panel_mode_flag) begin
            ion_pend_reg <= 1'b1; // RULE_02
         end else if (fetch_strobe) begin
            ion_pend_reg <= 1'b0;
         end
         if (grant_int) begin
            interrupt_enable_flag <= 1'b0;
         end else if (interrupts_off_op && !panel_mode_flag) begin
            interrupt_enable_flag <= 1'b0; // RULE_02
         end else if (ion_pend_reg && fetch_strobe) begin
            interrupt_enable_flag <= 1'b1;
         end else if (restore_flags_op && !panel_mode_flag) begin
            interrupt_enable_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         int_grant <= 1'b0;
      end else if (ce) begin
         int_grant <= grant_int;
      end
   end

   // grant sequencer: panel entry transfers and DMA hand-over
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= ptd_pkg::ST_RUN;
      end else if (ce) begin
         case (state_reg)
            ptd_pkg::ST_RUN: begin
               if (grant_panel) begin
                  state_reg <= ptd_pkg::ST_SAVE_PC;
               end else if (grant_dma) begin
                  state_reg <= ptd_pkg::ST_DMA_WAIT;
               end
            end
            ptd_pkg::ST_SAVE_PC: begin
               if (cycle_start) begin
                  state_reg <= ptd_pkg::ST_LOAD_PC;
               end
            end
            ptd_pkg::ST_LOAD_PC: begin
               if (cycle_start) begin
                  state_reg <= ptd_pkg::ST_RUN;
               end
            end
            ptd_pkg::ST_DMA_WAIT: begin
               if (cycle_start) begin
                  state_reg <= ptd_pkg::ST_DMA; // RULE_19
               end
            end
            ptd_pkg::ST_DMA: begin
               if (timing_state_two && dma_n_s) begin
                  state_reg <= ptd_pkg::ST_DMA_END; // RULE_22
               end
            end
            ptd_pkg::ST_DMA_END: begin
               if (cycle_start) begin
                  state_reg <= ptd_pkg::ST_RUN;
               end
            end
            default: begin
               state_reg <= ptd_pkg::ST_RUN;
            end
         endcase
      end
   end

   // DMA grant and release of the memory-side lines
   always_ff @(posedge clock) begin
      if (rst) begin
         dma_grant <= 1'b0;
         bus_oe_n  <= 1'b0;
      end else if (ce && cycle_start) begin
         if (state_reg == ptd_pkg::ST_DMA_WAIT) begin
            dma_grant <= 1'b1; // RULE_24
            bus_oe_n  <= 1'b1; // RULE_20
         end else if (state_reg == ptd_pkg::ST_DMA_END) begin
            dma_grant <= 1'b0;
            bus_oe_n  <= 1'b0;
         end
      end
   end

   // entry transfers: save PC, then point PC at the panel start
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_write     <= 1'b0;
         mem_addr      <= 12'h000;
         mem_data      <= 12'h000;
         pc_load       <= 1'b0;
         pc_load_value <= ptd_pkg::PANEL_START_PC;
      end else if (ce) begin
         mem_write <= 1'b0;
         pc_load   <= 1'b0;
         if (cycle_start && state_reg == ptd_pkg::ST_SAVE_PC) begin
            mem_write <= 1'b1; // RULE_06
            mem_addr  <= ptd_pkg::PC_SAVE_ADDR;
            mem_data  <= pc_value;
         end
         if (cycle_start && state_reg == ptd_pkg::ST_LOAD_PC) begin
            pc_load       <= 1'b1; // RULE_06
            pc_load_value <= ptd_pkg::PANEL_START_PC;
         end
      end
   end

   // panel or main memory selection for each reference
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_panel_sel <= 1'b0;
      end else if (ce) begin
         if (cycle_start && state_reg == ptd_pkg::ST_SAVE_PC) begin
            mem_panel_sel <= 1'b1;
         end else if (ref_valid) begin
            if (ref_kind == ptd_pkg::REF_IND_DATA) begin
               mem_panel_sel <= panel_mode_flag
                                && !main_data_select; // RULE_08
            end else begin
               mem_panel_sel <= panel_mode_flag; // RULE_07
            end
         end
      end
   end

   // terminal flag hold-off after a primary framing error
   ptd_flag_delay #(
      .DELAY_CYC (ptd_pkg::FLAG_DELAY_CYC)
   ) u_flag_delay (
      .clock        (clock),
      .rst          (rst),
      .ce           (ce),
      .hold_trigger (frame_err_primary),
      .flag_in      (term_ready_in),
      .flag_out     (term_flag)
   );

   a_panel_grant_entry: assert property (  // RULE_04
      @(posedge clock) disable iff (rst)
      ce && sample && panel_request && !panel_mode_flag
      |=> panel_mode_flag && state_reg == ptd_pkg::ST_SAVE_PC)
      else $error("panel request not granted");

   a_panel_blocks_dma: assert property (  // RULE_05
      @(posedge clock) disable iff (rst)
      ce && sample && panel_mode_flag
      |=> state_reg == ptd_pkg::ST_RUN && !int_grant)
      else $error("request accepted in panel mode");

   a_entry_save_zero: assert property (  // RULE_06
      @(posedge clock) disable iff (rst)
      ce && cycle_start && state_reg == ptd_pkg::ST_SAVE_PC
      |=> mem_write && mem_panel_sel
          && mem_addr == ptd_pkg::PC_SAVE_ADDR
          && mem_data == $past(pc_value))
      else $error("program counter not saved at zero");

   a_entry_load_ones: assert property (  // RULE_06
      @(posedge clock) disable iff (rst)
      ce && cycle_start && state_reg == ptd_pkg::ST_LOAD_PC
      |=> pc_load && pc_load_value == ptd_pkg::PANEL_START_PC)
      else $error("panel start address not loaded");

   a_dma_grant_release: assert property (  // RULE_19 RULE_20
      @(posedge clock) disable iff (rst)
      ce && cycle_start && state_reg == ptd_pkg::ST_DMA_WAIT
      |=> dma_grant && bus_oe_n)
      else $error("DMA grant or bus release missing");

   a_dma_resume: assert property (  // RULE_22
      @(posedge clock) disable iff (rst)
      ce && state_reg == ptd_pkg::ST_DMA && timing_state_two
      && dma_n_s |=> state_reg == ptd_pkg::ST_DMA_END && dma_grant)
      else $error("DMA release not seen at T2");

   a_iof_in_panel: assert property (  // RULE_02
      @(posedge clock) disable iff (rst)
      ce && interrupts_off_op && panel_mode_flag
      && !(ion_pend_reg && fetch_strobe)
      |=> interrupt_enable_flag == $past(interrupt_enable_flag))
      else $error("interrupts off acted in panel mode");

   a_rtf_exit: assert property (  // RULE_10
      @(posedge clock) disable iff (rst)
      ce && restore_flags_op && panel_mode_flag
      |=> !panel_mode_flag)
      else $error("restore flags did not leave panel mode");

   a_reset_state: assert property (  // RULE_11 RULE_25
      @(posedge clock) disable iff (rst)
      $past(rst) |-> !panel_mode_flag && !trap_flag && !run)
      else $error("reset did not clear panel state");

   a_trap_main_fetch: assert property (  // RULE_14
      @(posedge clock) disable iff (rst)
      ce && fetch_strobe && !panel_mode_flag
      && is_trapped(instr_word) |=> trap_flag ##1 panel_request)
      else $error("trapped instruction gave no request");
endmodule

// [rtl/ptd_pkg.sv]
// Summary of operation
// RULE_01: panel requests ignore device interrupt enable
// RULE_02: in panel mode interrupt on/off leave enable
// RULE_03: only internal board logic raises panel request; the code also takes the bus power request pin
// RULE_04: sample request in last execute, set flag
// RULE_05: panel mode ignores panel, DMA, interrupt requests
// RULE_06: save PC to panel zero, load all ones
// RULE_07: panel fetches and direct references use panel
// RULE_08: indirect data operands follow software memory select
// RULE_09: interrupts on exits panel midway next instruction
// RULE_10: restore flags also clears panel mode
// RULE_11: reset forces exit from panel mode
// RULE_12: framing error on either port requests panel
// RULE_13: primary framing error delays terminal flag 10us
// RULE_14: switch-or and trapped I/O codes request panel
// RULE_15: single-instruction mode traps every main fetch
// RULE_16: halt in main requests panel after group two
// RULE_17: reset holds run low, panel entry after release
// RULE_18: bus power request causes immediate panel request
// RULE_19: low DMA request sampled, grant next cycle start
// RULE_20: during grant the memory bus lines float
// RULE_21: DMA port drives released lines during grant
// RULE_22: resample DMA request at T2, resume after release
// RULE_23: priority reset, panel, DMA, interrupt, fetch
// RULE_24: DMA grant is driven active high
// RULE_25: reset clears panel mode and trap flags
package ptd_pkg;
   // memory words are 12 bits wide
   localparam int          WORD_W         = 12;
   localparam logic [11:0] PC_SAVE_ADDR   = 12'h000;
   localparam logic [11:0] PANEL_START_PC = 12'hFFF;
   // trapped I/O code range, inclusive
   localparam logic [11:0] IOT_TRAP_LO    = 12'hC07;
   localparam logic [11:0] IOT_TRAP_HI    = 12'hC26;
   // operate group two instruction fields
   localparam logic [3:0]  OPR2_PREFIX    = 4'hF;
   localparam int          OPR2_HI        = 11;
   localparam int          OPR2_LO        = 8;
   localparam int          OPR2_CLASS_BIT = 0;
   localparam int          OSR_BIT        = 2;
   localparam int          HLT_BIT        = 1;
   // terminal flag delay after a primary framing error
   localparam int          CLOCK_MHZ      = 50;
   localparam int          FLAG_DELAY_NS  = 10000;
   localparam int          FLAG_DELAY_CYC =
      (FLAG_DELAY_NS * CLOCK_MHZ + 999) / 1000;
   // synchronised bus pins, all active low
   localparam int          SYNC_W         = 3;
   localparam int          SYNC_DMA       = 0;
   localparam int          SYNC_INT       = 1;
   localparam int          SYNC_PWR       = 2;
   localparam logic [2:0]  SYNC_IDLE      = 3'h7;
   // kind of memory reference being issued
   typedef enum logic [1:0] {
      REF_FETCH    = 2'h0,
      REF_DIRECT   = 2'h1,
      REF_IND_JUMP = 2'h2,
      REF_IND_DATA = 2'h3
   } ptd_ref_t;
   // grant sequencer
   typedef enum logic [2:0] {
      ST_RUN      = 3'h0,
      ST_SAVE_PC  = 3'h1,
      ST_LOAD_PC  = 3'h2,
      ST_DMA_WAIT = 3'h3,
      ST_DMA      = 3'h4,
      ST_DMA_END  = 3'h5
   } ptd_state_t;
endpackage

// [rtl/ptd_flag_delay.sv]
module ptd_flag_delay #(
   parameter int DELAY_CYC = ptd_pkg::FLAG_DELAY_CYC
) (
   // clocking
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic ce,
   // flag path
   input  wire logic hold_trigger,
   input  wire logic flag_in,
   output logic      flag_out
);
   logic [15:0] cnt_reg;
   logic        done_reg;

   // count while a framing error holds the flag back
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_reg  <= 16'h0000;
         done_reg <= 1'b0;
      end else if (ce) begin
         if (!flag_in || !hold_trigger) begin
            cnt_reg  <= 16'h0000;
            done_reg <= 1'b0;
         end else if (cnt_reg == 16'(DELAY_CYC - 1)) begin
            done_reg <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         flag_out <= 1'b0;
      end else if (ce) begin
         flag_out <= flag_in && (!hold_trigger || done_reg); // RULE_13
      end
   end
endmodule

// [verif/ptd_dma_port.sv]
module ptd_dma_port (
   // clocking
   input  wire logic        clock,
   // control from the bench
   input  wire logic        start,
   input  wire logic [3:0]  hold_cycles,
   // bus side
   input  wire logic        dma_grant,
   output logic             dma_request_n,
   output logic [11:0]      dx_drive,
   output logic             busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int n;
   logic go;
   initial begin
      dma_request_n = 1'b1;
      dx_drive      = 12'h0a5a;
      busy          = 1'b0;
      forever begin
         @(posedge clock);
         go = start;
         #1;
         // released lines show a changing pattern, never a stale value
         dx_drive = ~dx_drive;
         if (go === 1'b1) begin
            busy = 1'b1;
            dma_request_n = 1'b0;
            for (n = 0; n < 300 && dma_grant !== 1'b1; n++) begin
               @(posedge clock);
               #1;
            end
            for (n = 0; n < hold_cycles; n++) begin
               dx_drive = ~dx_drive;
               @(posedge clock);
               #1;
            end
            dma_request_n = 1'b1;
            busy = 1'b0;
         end
      end
   end
endmodule

// [verif/ptd_panel_trap_tb.sv]
module ptd_panel_trap_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst, cycle_start, timing_state_two, last_execute;
   logic        operate_group2_cycle, fetch_strobe, interrupts_on_op;
   logic        interrupts_off_op, restore_flags_op, ref_valid;
   logic        single_step_mode, main_data_select, request_clear;
   logic        frame_err_primary, frame_err_secondary, term_ready_in;
   logic        dma_request_n, dev_int_request_n, power_request_n;
   logic        panel_mode_flag, panel_request, trap_flag, run, term_flag;
   logic        interrupt_enable_flag, int_grant, mem_panel_sel, mem_write;
   logic        pc_load, dma_grant, bus_oe_n, dma_start, dma_busy;
   logic [1:0]  ref_kind;
   logic [3:0]  hold;
   logic [11:0] instr_word, pc_value, mem_addr, mem_data, pc_load_value, dx;
   logic [31:0] seed;
   logic [11:0] exp_q [$];
   int          phase, cyc = 0, n_fail = 0, checks = 0;
   // word, then single step, group two pulse, power, second port, expect
   logic [16:0] rows [10] = '{
      {12'h0c06, 5'h00}, {12'h0c07, 5'h01}, {12'h0c26, 5'h01},
      {12'h0c27, 5'h00}, {12'h0f04, 5'h01}, {12'h0f02, 5'h09},
      {12'h0f03, 5'h08}, {12'h0000, 5'h11}, {12'h0000, 5'h05},
      {12'h0000, 5'h03}};

   ptd_panel_trap uut (.ce(1'b1), .*);
   ptd_dma_port dport (.clock(clock), .start(dma_start), .hold_cycles(hold),
      .dma_grant(dma_grant), .dma_request_n(dma_request_n),
      .dx_drive(dx), .busy(dma_busy));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic enter;
      int k;
      for (k = 0; k < 80 && pc_load !== 1'b1; k++) tick;
      chk_bit(pc_load, 1'b1);
      chk_bit(panel_mode_flag, 1'b1);
   endtask
   // firmware side: drop the sources, clear the flags, leave by restore
   task automatic leave;
      power_request_n = 1'b1;
      frame_err_primary = 1'b0;
      frame_err_secondary = 1'b0;
      single_step_mode = 1'b0;
      repeat (4) tick;
      request_clear = 1'b1;
      tick;
      request_clear = 1'b0;
      restore_flags_op = 1'b1;
      tick;
      restore_flags_op = 1'b0;
      repeat (2) tick;
      chk_bit(panel_mode_flag, 1'b0);
   endtask
   task automatic dma_wait;
      int k;
      for (k = 0; k < 300 && dma_grant !== 1'b1; k++) tick;
      chk_bit(dma_grant, 1'b1);
      for (k = 0; k < 80 && dma_grant !== 1'b0; k++) tick;
      chk_bit(dma_grant, 1'b0);
   endtask

   always #10 clock = ~clock;
   // five clocks to a major cycle, every other one ends an instruction
   always @(posedge clock) begin
      #1;
      phase = (phase == 4) ? 0 : phase + 1;
      cycle_start = (phase == 0);
      timing_state_two = (phase == 2);
      if (phase == 0) last_execute = ~last_execute;
   end
   always @(posedge clock) begin
      chk_bit(bus_oe_n, dma_grant);
      if (mem_write === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk_bit(mem_write, 1'b0);
         end else begin
            chk_word(mem_data, exp_q.pop_front());
            chk_word(mem_addr, 12'h0000);
            chk_bit(mem_panel_sel, 1'b1);
         end
      end
      if (pc_load === 1'b1) chk_word(pc_load_value, 12'h0fff);
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         stop_test;
      end
   end

   initial begin
      int k;
      clock = 1'b0;
      rst = 1'b1;
      phase = 0;
      {cycle_start, timing_state_two, last_execute, operate_group2_cycle,
       fetch_strobe, interrupts_on_op, interrupts_off_op, restore_flags_op,
       ref_valid, single_step_mode, main_data_select, request_clear,
       frame_err_primary, frame_err_secondary, term_ready_in,
       dma_start} = '0;
      {dev_int_request_n, power_request_n} = 2'h3;
      ref_kind = 2'h0;
      instr_word = 12'h0000;
      seed = 32'h4110_c056;
      pc_value = seed[11:0];
      hold = 4'h3;
      exp_q.push_back(pc_value);
      repeat (2) tick;
      chk_bit(run, 1'b0);
      rst = 1'b0;
      tick;
      chk_bit(run, 1'b1);
      tick;
      chk_bit(panel_request, 1'b1);
      enter;
      leave;
      $display("test reset_entry done");
      foreach (rows[i]) begin
         seed = lfsr(seed);
         pc_value = seed[11:0];
         single_step_mode = rows[i][4];
         instr_word = rows[i][4] ? seed[23:12] : rows[i][16:5];
         power_request_n = !rows[i][2];
         frame_err_secondary = rows[i][1];
         if (rows[i][0]) exp_q.push_back(pc_value);
         fetch_strobe = 1'b1;
         tick;
         fetch_strobe = 1'b0;
         operate_group2_cycle = rows[i][3];
         tick;
         operate_group2_cycle = 1'b0;
         repeat (3) tick;
         chk_bit(panel_request, rows[i][0]);
         if (rows[i][0]) begin
            enter;
            leave;
         end
         $display("test trap row %0d done", i);
      end
      seed = lfsr(seed);
      pc_value = seed[11:0];
      exp_q.push_back(pc_value);
      frame_err_primary = 1'b1;
      term_ready_in = 1'b1;
      enter;
      repeat (380) tick;
      chk_bit(term_flag, 1'b0);
      repeat (140) tick;
      chk_bit(term_flag, 1'b1);
      for (k = 0; k < 8; k++) begin
         ref_kind = k[1:0];
         main_data_select = k[2];
         ref_valid = 1'b1;
         tick;
         ref_valid = 1'b0;
         tick;
         chk_bit(mem_panel_sel, !(k[2] && k[1:0] == 2'h3));
      end
      frame_err_primary = 1'b0;
      term_ready_in = 1'b0;
      dma_start = 1'b1;
      tick;
      dma_start = 1'b0;
      repeat (30) begin
         tick;
         chk_bit(dma_grant, 1'b0);
      end
      request_clear = 1'b1;
      interrupts_off_op = 1'b1;
      tick;
      {request_clear, interrupts_off_op, interrupts_on_op} = 3'h1;
      tick;
      interrupts_on_op = 1'b0;
      chk_bit(panel_mode_flag, 1'b1);
      fetch_strobe = 1'b1;
      tick;
      fetch_strobe = 1'b0;
      repeat (6) tick;
      chk_bit(panel_mode_flag, 1'b0);
      chk_bit(interrupt_enable_flag, 1'b0);
      dma_wait;
      for (k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         hold = k ? seed[3:0] : 4'h0;
         dma_start = 1'b1;
         tick;
         dma_start = 1'b0;
         dma_wait;
      end
      $display("test panel_exit_dma done");
      seed = lfsr(seed);
      pc_value = seed[11:0];
      exp_q.push_back(pc_value);
      instr_word = 12'h0c10;
      fetch_strobe = 1'b1;
      dma_start = 1'b1;
      tick;
      {fetch_strobe, dma_start} = 2'h0;
      enter;
      chk_bit(dma_grant, 1'b0);
      chk_bit(trap_flag, 1'b1);
      rst = 1'b1;
      exp_q.push_back(pc_value);
      repeat (2) tick;
      chk_bit(panel_mode_flag, 1'b0);
      chk_bit(trap_flag, 1'b0);
      chk_bit(run, 1'b0);
      rst = 1'b0;
      enter;
      leave;
      dma_wait;
      instr_word = 12'h0000;
      interrupts_on_op = 1'b1;
      tick;
      {interrupts_on_op, fetch_strobe} = 2'h1;
      tick;
      fetch_strobe = 1'b0;
      dev_int_request_n = 1'b0;
      chk_bit(interrupt_enable_flag, 1'b1);
      for (k = 0; k < 30 && int_grant !== 1'b1; k++) tick;
      chk_bit(int_grant, 1'b1);
      chk_bit(interrupt_enable_flag, 1'b0);
      $display("test midrun_reset done");
      stop_test;
   end
endmodule
